// >>> hdl/srd_ctrl.sv
// supply switching, undervoltage reset, io, monitor, debug and fail-safe control
`timescale 1ns/10ps
module srd_ctrl
	import srd_pkg::*;
#(
	parameter int RST_PULSE_CYC = SRD_RST_PULSE_CYC,
	parameter int IO_N          = SRD_IO_N
) (
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic                  ce,
	// spi command strobes and data from the register decoder
	input  wire logic                  can_on_cmd,
	input  wire logic                  can_off_cmd,
	input  wire logic                  aux_on_cmd,
	input  wire logic                  aux_off_cmd,
	input  wire logic                  aux_level_wr,
	input  wire logic                  aux_level_33,
	input  wire logic                  aux_int_en,
	input  wire logic                  flag_clr,
	input  wire logic                  uv_lower_sel,
	input  wire logic                  io_mode_wr,
	input  wire logic [2*IO_N-1:0]     io_mode_data,
	input  wire logic                  mux_wr,
	input  wire logic [2:0]            mux_data,
	input  wire logic                  mux_load_wr,
	input  wire logic                  mux_load_data,
	input  wire logic                  leave_debug_cmd,
	input  wire logic                  safe_cfg_wr,
	input  wire logic [SRD_SAFE_W-1:0] safe_cfg_data,
	// mode machine status
	input  wire logic                  init_entry,
	input  wire logic                  normal_mode,
	input  wire logic                  low_power,
	input  wire logic                  lp_vdd_on,
	input  wire logic                  wd_fail,
	// analog comparator and pin levels
	input  wire logic                  dbg_window_pin,
	input  wire logic [SRD_SAFE_W-1:0] dbg_strap_pin,
	input  wire logic                  uv_upper_pin,
	input  wire logic                  uv_lower_pin,
	input  wire logic                  aux_uv_pin,
	input  wire logic                  aux_oc_pin,
	input  wire logic                  fault_pin,
	input  wire logic [IO_N-1:0]       io_ovl_pin,
	// supply controls
	output logic                       can_supply_en,
	output logic                       aux_supply_en,
	output logic                       aux_supply_33,
	output logic                       aux_uv_flag,
	output logic                       aux_oc_flag,
	// reset, interrupt and fail-safe pins
	output logic                       rst_pin_o,
	output logic                       rst_pin_oe,
	output logic                       int_n,
	output logic                       uv_int_flag,
	output logic                       safe_pin_o,
	output logic                       safe_pin_oe,
	output logic [SRD_SAFE_W-1:0]      safe_mode,
	// io pins
	output logic [IO_N-1:0]            io_o,
	output logic [IO_N-1:0]            io_oe,
	output logic [IO_N-1:0]            io_ovl_flag,
	// analog monitor
	output logic [2:0]                 analog_monitor_sel,
	output logic                       analog_monitor_load,
	// debug
	output logic                       debug_active,
	output logic                       wd_required
);
	// ************************************************************
	// synchronised pins
	// ************************************************************
	srd_sync_if #(.W(SRD_S_W)) pins ();

	assign pins.raw = {io_ovl_pin, dbg_strap_pin, fault_pin, aux_oc_pin, aux_uv_pin,
	                   uv_lower_pin, uv_upper_pin, dbg_window_pin};

	srd_sync #(.W(SRD_S_W)) u_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.ce    (ce),
		.s     (pins)
	);

	logic                  dbg_win;
	logic                  uv_up;
	logic                  uv_lo;
	logic                  aux_fault;
	logic                  fault_s;
	logic [SRD_SAFE_W-1:0] strap_s;
	logic [IO_N-1:0]       ovl_s;

	assign dbg_win   = pins.sync[SRD_S_DBG];
	assign uv_up     = pins.sync[SRD_S_UVU];
	assign uv_lo     = pins.sync[SRD_S_UVL];
	assign aux_fault = pins.sync[SRD_S_AUV] | pins.sync[SRD_S_AOC];
	assign fault_s   = pins.sync[SRD_S_FLT];
	assign strap_s   = pins.sync[SRD_S_STRAP +: SRD_SAFE_W];
	assign ovl_s     = pins.sync[SRD_S_OVL +: IO_N];

	// ************************************************************
	// debug mode
	// ************************************************************
	logic debug_r;
	logic debug_nxt;

	always_comb begin
		debug_nxt = debug_r;
		if (init_entry)
			debug_nxt = dbg_win;
		if (debug_r && !dbg_win)
			debug_nxt = 1'b0;
		if (leave_debug_cmd)
			debug_nxt = 1'b0;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			debug_r <= 1'b0;
		else if (ce)
			debug_r <= debug_nxt;
	end

	assign debug_active = debug_r;
	assign wd_required  = !debug_r;

	// ************************************************************
	// can supply regulator
	// ************************************************************
	logic can_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			can_r <= 1'b0;
		else if (ce && can_on_cmd)
			can_r <= 1'b1;
		else if (ce && can_off_cmd)
			can_r <= 1'b0;
	end

	assign can_supply_en = can_r | debug_r;

	// ************************************************************
	// auxiliary supply with fault shutdown
	// ************************************************************
	logic aux_en_r;
	logic aux_33_r;
	logic aux_uv_r;
	logic aux_oc_r;

	// fault wins over an on command in the same cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			aux_en_r <= 1'b0;
		else if (ce && aux_fault)
			aux_en_r <= 1'b0;
		else if (ce && aux_on_cmd)
			aux_en_r <= 1'b1;
		else if (ce && aux_off_cmd)
			aux_en_r <= 1'b0;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			aux_33_r <= SRD_AUX_33_RST;
		else if (ce && aux_level_wr)
			aux_33_r <= aux_level_33;
	end

	// sticky fault flags, a new fault beats the clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aux_uv_r <= 1'b0;
			aux_oc_r <= 1'b0;
		end else if (ce) begin
			aux_uv_r <= pins.sync[SRD_S_AUV] | (aux_uv_r & !flag_clr);
			aux_oc_r <= pins.sync[SRD_S_AOC] | (aux_oc_r & !flag_clr);
		end
	end

	assign aux_supply_en = aux_en_r;
	assign aux_supply_33 = aux_33_r;
	assign aux_uv_flag   = aux_uv_r;
	assign aux_oc_flag   = aux_oc_r;

	// ************************************************************
	// undervoltage and watchdog reset, interrupt
	// ************************************************************
	logic                 two_level;
	logic                 uv_watch;
	logic                 uv_rst_cause;
	logic                 uv_int_cause;
	logic                 wd_rst_cause;
	logic                 rst_trig;
	logic [SRD_CNT_W-1:0] rst_cnt_r;
	logic                 uv_int_r;

	// two-level scheme applies only in normal mode
	// undervoltage watch stays on except in low power with the main supply off
	assign uv_watch     = !low_power | lp_vdd_on;
	assign two_level    = uv_lower_sel & normal_mode;
	assign uv_rst_cause = uv_watch & (two_level ? uv_lo : uv_up);
	assign uv_int_cause = two_level & uv_up;
	assign wd_rst_cause = wd_fail & !debug_r;
	assign rst_trig     = uv_rst_cause | wd_rst_cause;

	// pulse stretcher keeps reset low for the documented pulse
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			rst_cnt_r <= '0;
		else if (ce && rst_trig)
			rst_cnt_r <= SRD_CNT_W'(RST_PULSE_CYC);
		else if (ce && rst_cnt_r != '0)
			rst_cnt_r <= rst_cnt_r - SRD_CNT_W'(1);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			uv_int_r <= 1'b0;
		else if (ce)
			uv_int_r <= uv_int_cause | (uv_int_r & !flag_clr);
	end

	assign rst_pin_o   = 1'b0;
	assign rst_pin_oe  = (rst_cnt_r != '0);
	assign uv_int_flag = uv_int_r;
	assign int_n       = !(uv_int_r | (aux_int_en & (aux_uv_r | aux_oc_r)));

	// ************************************************************
	// configurable io pins
	// ************************************************************
	logic [2*IO_N-1:0] io_mode_r;
	logic [IO_N-1:0]   io_ovl_r;
	logic [IO_N-1:0]   ovl_live;

	assign ovl_live = low_power ? '0 : ovl_s;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			io_mode_r <= '0;
		else if (ce && io_mode_wr)
			io_mode_r <= io_mode_data;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			io_ovl_r <= '0;
		else if (ce)
			io_ovl_r <= ovl_live | (io_ovl_r & ~{IO_N{flag_clr}});
	end

	// drive decode, an overloaded pin stays off until flags clear
	always_comb begin
		for (int i = 0; i < IO_N; i++) begin
			io_o[i]  = (io_mode_r[2*i +: 2] == SRD_IO_HIGH);
			io_oe[i] = ((io_mode_r[2*i +: 2] == SRD_IO_HIGH) ||
			            (io_mode_r[2*i +: 2] == SRD_IO_LOW)) && !io_ovl_r[i];
		end
	end

	assign io_ovl_flag = io_ovl_r;

	// ************************************************************
	// analog monitor selection
	// ************************************************************
	logic [2:0] mux_r;
	logic       mux_load_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			mux_r <= SRD_MUX_GND;
		else if (ce && !can_supply_en)
			mux_r <= SRD_MUX_GND;
		else if (ce && mux_wr)
			mux_r <= mux_data;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			mux_load_r <= 1'b0;
		else if (ce && mux_load_wr)
			mux_load_r <= mux_load_data;
	end

	assign analog_monitor_sel  = can_supply_en ? mux_r : SRD_MUX_GND;
	assign analog_monitor_load = mux_load_r;

	// ************************************************************
	// fail-safe selection and safe output
	// ************************************************************
	logic                  safe_spi_v_r;
	logic [SRD_SAFE_W-1:0] safe_spi_r;
	logic [SRD_SAFE_W-1:0] safe_strap_r;
	logic                  safe_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			safe_spi_v_r <= 1'b0;
			safe_spi_r   <= SRD_SAFE_DEFAULT;
		end else if (ce && safe_cfg_wr) begin
			safe_spi_v_r <= 1'b1;
			safe_spi_r   <= safe_cfg_data;
		end
	end

	// strap caught at init entry, not when debug is chosen
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			safe_strap_r <= SRD_SAFE_DEFAULT;
		else if (ce && init_entry)
			safe_strap_r <= dbg_win ? SRD_SAFE_DEFAULT : strap_s;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			safe_r <= 1'b0;
		else if (ce && fault_s)
			safe_r <= 1'b1;
	end

	assign safe_mode   = safe_spi_v_r ? safe_spi_r : safe_strap_r;
	assign safe_pin_o  = 1'b0;
	assign safe_pin_oe = safe_r;
endmodule : srd_ctrl

// >>> shared/srd_pkg.sv
// constants, codes and timing for the supply, reset and debug control block
//
// Function
// - can supply off until commanded on
// - debug mode forces can supply on
// - aux supply level selects five or three-three
// - aux supply off until commanded on
// - aux fault disables, flags, optional interrupt
// - reset on undervoltage or watchdog failure
// - upper threshold chooses reset or interrupt
// - lower option, normal mode only: interrupt upper, reset lower
// - io pins input at reset, later configurable
// - low power keeps io state, no protection
// - one selected source to analog monitor
// - load resistor control on analog monitor
// - can supply off ignores and grounds monitor
// - debug window sampled on init entry
// - debug mode needs no watchdog refresh
// - debug active flag readable
// - leaving window exits debug, watchdog starts
// - leave-debug command beats window voltage
// - spi fail-safe setting overrides resistor
// - debug ignores resistor fail-safe selection
// - fault drives fail-safe output low
package srd_pkg;
	// ************************************************************
	// io pin modes
	// ************************************************************
	typedef enum logic [1:0] {
		SRD_IO_INPUT = 2'h0,
		SRD_IO_HIGH  = 2'h1,
		SRD_IO_LOW   = 2'h2,
		SRD_IO_HIZ   = 2'h3
	} srd_io_mode_e;

	// ************************************************************
	// analog monitor sources
	// ************************************************************
	typedef enum logic [2:0] {
		SRD_MUX_GND    = 3'h0,
		SRD_MUX_VSUP   = 3'h1,
		SRD_MUX_SENSE  = 3'h2,
		SRD_MUX_IO0    = 3'h3,
		SRD_MUX_IO1    = 3'h4,
		SRD_MUX_REF    = 3'h5,
		SRD_MUX_TEMP   = 3'h6,
		SRD_MUX_CURR   = 3'h7
	} srd_mux_e;

	// ************************************************************
	// widths, reset values and timing
	// ************************************************************
	localparam int          SRD_IO_N         = 4;
	localparam int          SRD_SAFE_W       = 2;
	localparam logic [1:0]  SRD_SAFE_DEFAULT = 2'h0;
	localparam logic        SRD_AUX_33_RST   = 1'b0; // five volt level after reset
	localparam int          SRD_CLK_NS       = 40;
	localparam int          SRD_RST_PULSE_NS = 1000000; // reset pulse, 1.0 ms
	localparam int          SRD_RST_PULSE_CYC = (SRD_RST_PULSE_NS + SRD_CLK_NS - 1) / SRD_CLK_NS;
	localparam int          SRD_CNT_W        = 16;
	// synchroniser bit positions
	localparam int          SRD_S_DBG        = 0;
	localparam int          SRD_S_UVU        = 1;
	localparam int          SRD_S_UVL        = 2;
	localparam int          SRD_S_AUV        = 3;
	localparam int          SRD_S_AOC        = 4;
	localparam int          SRD_S_FLT        = 5;
	localparam int          SRD_S_STRAP      = 6;
	localparam int          SRD_S_OVL        = 8;
	localparam int          SRD_S_W          = 12;
endpackage : srd_pkg

// >>> shared/srd_sync_if.sv
// bundle of raw pin levels and their synchronised copies
`timescale 1ns/10ps
interface srd_sync_if #(parameter int W = 12);
	logic [W-1:0] raw;
	logic [W-1:0] sync;
	modport syn (input raw, output sync);
	modport user (output raw, input sync);
endinterface : srd_sync_if

// >>> hdl/srd_sync.sv
// two flip-flop synchroniser for the asynchronous status pins
`timescale 1ns/10ps
module srd_sync
	import srd_pkg::*;
#(
	parameter int W = SRD_S_W
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ce,
	srd_sync_if.syn   s
);
	logic [W-1:0] meta_r;
	logic [W-1:0] hold_r;

	// ************************************************************
	// first stage feeds only the second
	// ************************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '0;
			hold_r <= '0;
		end else if (ce) begin
			meta_r <= s.raw;
			hold_r <= meta_r;
		end
	end

	assign s.sync = hold_r;
endmodule : srd_sync

// >>> test/srd_ctrl_asserts.sv
// port assertions for the supply, reset and debug control block
`timescale 1ns/10ps
module srd_ctrl_asserts
	import srd_pkg::*;
#(
	parameter int RST_PULSE_CYC = 8
) (
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic       ce,
	input wire logic       can_on_cmd,
	input wire logic       mux_wr,
	input wire logic [2:0] mux_data,
	input wire logic       leave_debug_cmd,
	input wire logic       init_entry,
	input wire logic       aux_int_en,
	input wire logic       can_supply_en,
	input wire logic       aux_supply_en,
	input wire logic       aux_uv_flag,
	input wire logic       aux_oc_flag,
	input wire logic       rst_pin_oe,
	input wire logic       int_n,
	input wire logic       uv_int_flag,
	input wire logic       safe_pin_o,
	input wire logic       safe_pin_oe,
	input wire logic [2:0] analog_monitor_sel,
	input wire logic       debug_active,
	input wire logic       wd_required
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ************************************************************
	// supply, monitor, reset and debug relations
	// ************************************************************
	a_can_cmd_only: assert property ($rose(can_supply_en) |-> $past(can_on_cmd) || debug_active)
		else $error("can supply rose without command");
	a_can_debug_on: assert property (debug_active |-> can_supply_en)
		else $error("can supply off in debug");
	a_aux_fault_off: assert property ($rose(aux_uv_flag) || $rose(aux_oc_flag) |-> !aux_supply_en)
		else $error("aux supply on after fault");
	a_int_source: assert property (int_n != (uv_int_flag || (aux_int_en && (aux_uv_flag || aux_oc_flag))))
		else $error("interrupt level wrong");
	a_rst_pulse_len: assert property ($rose(rst_pin_oe) |-> rst_pin_oe [*8])
		else $error("reset pulse too short");
	a_mux_ignored: assert property (!can_supply_en |-> analog_monitor_sel == 3'h0)
		else $error("monitor selected with can supply off");
	a_mux_select: assert property (ce && mux_wr && can_supply_en |=>
		analog_monitor_sel == $past(mux_data) || !can_supply_en)
		else $error("monitor selection not taken");
	a_leave_debug: assert property (ce && leave_debug_cmd |=> !debug_active)
		else $error("debug kept after leave command");
	a_debug_flag: assert property (wd_required != debug_active)
		else $error("watchdog need disagrees with debug");
	a_debug_entry: assert property ($rose(debug_active) |-> $past(init_entry))
		else $error("debug entered outside init entry");
	a_safe_sticky: assert property (safe_pin_oe |=> safe_pin_oe && !safe_pin_o)
		else $error("safe output released");
endmodule : srd_ctrl_asserts

bind srd_ctrl srd_ctrl_asserts #(.RST_PULSE_CYC(RST_PULSE_CYC)) chk_u (.clk, .rst_n, .ce, .can_on_cmd, .mux_wr,
	.mux_data, .leave_debug_cmd, .init_entry, .aux_int_en, .can_supply_en, .aux_supply_en, .aux_uv_flag,
	.aux_oc_flag, .rst_pin_oe, .int_n, .uv_int_flag, .safe_pin_o, .safe_pin_oe, .analog_monitor_sel,
	.debug_active, .wd_required);

// >>> test/srd_mcu_model.sv
// controller side model issuing supply and monitor commands
`timescale 1ns/10ps
module srd_mcu_model #(
	parameter int SETTLE = 6
) (
	input  wire logic  clk,
	output logic       can_on_cmd,
	output logic       can_off_cmd,
	output logic       mux_wr,
	output logic [2:0] mux_data
);
	// idle command lines
	initial begin
		{can_on_cmd, can_off_cmd, mux_wr, mux_data} = '0;
	end
	// switch the can supply, then let its capacitor charge before any select
	task automatic power_can(input logic on);
		can_on_cmd = on;
		can_off_cmd = !on;
		@(negedge clk);
		{can_on_cmd, can_off_cmd} = 2'h0;
		repeat (SETTLE) @(negedge clk);
	endtask : power_can
	// one monitor source select strobe
	task automatic pick(input logic [2:0] s);
		mux_data = s;
		mux_wr = 1'b1;
		@(negedge clk);
		mux_wr = 1'b0;
		@(negedge clk);
	endtask : pick
endmodule : srd_mcu_model

// >>> test/tb.sv
// self-checking testbench for the supply, reset and debug control block
`timescale 1ns/10ps
module tb;
	import srd_pkg::*;
	logic       clk, rst_n, ce, can_on_cmd, can_off_cmd, aux_on_cmd, aux_off_cmd, aux_level_wr, aux_level_33;
	logic       aux_int_en, flag_clr, uv_lower_sel, io_mode_wr, mux_wr, mux_load_wr, mux_load_data;
	logic       leave_debug_cmd, safe_cfg_wr, init_entry, normal_mode, low_power, lp_vdd_on, wd_fail;
	logic       dbg_window_pin, uv_upper_pin, uv_lower_pin, aux_uv_pin, aux_oc_pin, fault_pin;
	logic       can_supply_en, aux_supply_en, aux_supply_33, aux_uv_flag, aux_oc_flag, rst_pin_o, rst_pin_oe;
	logic       int_n, uv_int_flag, safe_pin_o, safe_pin_oe, analog_monitor_load, debug_active, wd_required;
	logic [7:0] io_mode_data;
	logic [2:0] mux_data, analog_monitor_sel;
	logic [1:0] safe_cfg_data, dbg_strap_pin, safe_mode;
	logic [3:0] io_ovl_pin, io_o, io_oe, io_ovl_flag;
	int         err_total, samples_checked;
	// monitor source rows: select code beside expected selection
	localparam logic [5:0] ROWS [8] = '{6'h00, 6'h09, 6'h12, 6'h1B, 6'h24, 6'h2D, 6'h36, 6'h3F};

	srd_ctrl #(.RST_PULSE_CYC(8)) dut_u (.clk, .rst_n, .ce, .can_on_cmd, .can_off_cmd, .aux_on_cmd, .aux_off_cmd,
		.aux_level_wr, .aux_level_33, .aux_int_en, .flag_clr, .uv_lower_sel, .io_mode_wr, .io_mode_data, .mux_wr,
		.mux_data, .mux_load_wr, .mux_load_data, .leave_debug_cmd, .safe_cfg_wr, .safe_cfg_data, .init_entry,
		.normal_mode, .low_power, .lp_vdd_on, .wd_fail, .dbg_window_pin, .dbg_strap_pin, .uv_upper_pin,
		.uv_lower_pin, .aux_uv_pin, .aux_oc_pin, .fault_pin, .io_ovl_pin, .can_supply_en, .aux_supply_en,
		.aux_supply_33, .aux_uv_flag, .aux_oc_flag, .rst_pin_o, .rst_pin_oe, .int_n, .uv_int_flag, .safe_pin_o,
		.safe_pin_oe, .safe_mode, .io_o, .io_oe, .io_ovl_flag, .analog_monitor_sel, .analog_monitor_load,
		.debug_active, .wd_required);
	srd_mcu_model mcu_u (.clk, .can_on_cmd, .can_off_cmd, .mux_wr, .mux_data);

	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict
	// bounded wait for the reset pulse to end, a stuck pulse counts as a mismatch
	task automatic rst_gone;
		for (int i = 0; i < 40 && rst_pin_oe !== 1'b0; i++)
			cyc(1);
		if (rst_pin_oe !== 1'b0)
			err_total++;
	endtask : rst_gone
	task automatic init_pulse;
		init_entry = 1'b1;
		cyc(1);
		init_entry = 1'b0;
		cyc(1);
	endtask : init_pulse

	// main sequence
	initial begin
		{rst_n, aux_on_cmd, aux_off_cmd, aux_level_wr, aux_level_33, aux_int_en, flag_clr, uv_lower_sel,
			io_mode_wr, io_mode_data, mux_load_wr, mux_load_data, leave_debug_cmd, safe_cfg_wr, safe_cfg_data,
			init_entry, normal_mode, low_power, lp_vdd_on, wd_fail, dbg_window_pin, dbg_strap_pin, uv_upper_pin,
			uv_lower_pin, aux_uv_pin, aux_oc_pin, fault_pin, io_ovl_pin, err_total, samples_checked} = '0;
		ce = 1'b1;
		cyc(8);
		rst_n = 1'b1;
		cyc(1);
		chk(can_supply_en, 0);
		chk({aux_supply_33, aux_supply_en}, 0);
		chk(io_oe, 0);
		chk({debug_active, wd_required, int_n}, 3'h3);
		mcu_u.pick(3'h5);
		chk(analog_monitor_sel, 0);
		$display("test reset finished");
		mcu_u.power_can(1'b1);
		chk(can_supply_en, 1);
		for (int i = 0; i < 8; i++) begin
			mcu_u.pick(ROWS[i][5:3]);
			chk(analog_monitor_sel, ROWS[i][2:0]);
		end
		{mux_load_data, mux_load_wr} = 2'h3;
		cyc(1);
		mux_load_wr = 1'b0;
		cyc(1);
		chk(analog_monitor_load, 1);
		$display("test monitor finished");
		{aux_level_33, aux_level_wr, aux_on_cmd, aux_int_en} = 4'hF;
		cyc(1);
		{aux_level_wr, aux_on_cmd} = 2'h0;
		cyc(1);
		chk({aux_supply_33, aux_supply_en}, 2'h3);
		// a frozen clock enable ignores the off command until it returns
		ce = 1'b0;
		aux_off_cmd = 1'b1;
		cyc(2);
		ce = 1'b1;
		chk(aux_supply_en, 1);
		aux_level_33 = 1'b0;
		aux_level_wr = 1'b1;
		cyc(1);
		{aux_off_cmd, aux_level_wr} = 2'h0;
		chk({aux_supply_33, aux_supply_en}, 2'h0);
		aux_on_cmd = 1'b1;
		cyc(1);
		aux_on_cmd = 1'b0;
		aux_oc_pin = 1'b1;
		cyc(4);
		chk({aux_oc_flag, aux_supply_en, int_n}, 3'h4);
		aux_oc_pin = 1'b0;
		cyc(3);
		flag_clr = 1'b1;
		cyc(1);
		flag_clr = 1'b0;
		cyc(1);
		chk(int_n, 1);
		// undervoltage fault with the interrupt left disabled
		aux_int_en = 1'b0;
		aux_on_cmd = 1'b1;
		cyc(1);
		aux_on_cmd = 1'b0;
		aux_uv_pin = 1'b1;
		cyc(4);
		chk({aux_uv_flag, aux_oc_flag, aux_supply_en, int_n}, 4'h9);
		aux_uv_pin = 1'b0;
		$display("test aux finished");
		io_mode_data = 8'hE4;
		io_mode_wr = 1'b1;
		cyc(1);
		io_mode_wr = 1'b0;
		cyc(1);
		chk({io_oe, io_o & io_oe}, 8'h62);
		{low_power, io_ovl_pin} = 5'h1F;
		cyc(4);
		chk({io_oe, io_ovl_flag}, 8'h60);
		io_ovl_pin = 4'h0;
		cyc(3);
		// outside low power an overload turns its pin off until the flags clear
		low_power = 1'b0;
		io_ovl_pin = 4'h2;
		cyc(4);
		chk({io_oe, io_ovl_flag}, 8'h42);
		io_ovl_pin = 4'h0;
		cyc(3);
		flag_clr = 1'b1;
		cyc(1);
		flag_clr = 1'b0;
		chk({io_oe, io_ovl_flag, aux_uv_flag}, 9'h0C0);
		$display("test io finished");
		{normal_mode, uv_lower_sel, uv_upper_pin} = 3'h7;
		cyc(4);
		chk({int_n, uv_int_flag, rst_pin_oe}, 3'h2);
		uv_lower_pin = 1'b1;
		cyc(4);
		chk({rst_pin_o, rst_pin_oe}, 2'h1);
		{uv_upper_pin, uv_lower_pin} = 2'h0;
		rst_gone;
		// single threshold, also watched in low power with the main supply on
		{uv_lower_sel, low_power, lp_vdd_on, uv_upper_pin} = 4'h7;
		cyc(4);
		chk(rst_pin_oe, 1);
		uv_upper_pin = 1'b0;
		rst_gone;
		{low_power, lp_vdd_on} = 2'h0;
		wd_fail = 1'b1;
		cyc(2);
		chk(rst_pin_oe, 1);
		wd_fail = 1'b0;
		rst_gone;
		$display("test undervoltage finished");
		{dbg_window_pin, dbg_strap_pin} = 3'h7;
		cyc(3);
		init_pulse;
		chk({debug_active, wd_required, safe_mode}, 4'h8);
		mcu_u.power_can(1'b0);
		chk(can_supply_en, 1);
		wd_fail = 1'b1;
		cyc(3);
		chk(rst_pin_oe, 0);
		wd_fail = 1'b0;
		leave_debug_cmd = 1'b1;
		cyc(1);
		leave_debug_cmd = 1'b0;
		cyc(1);
		chk({debug_active, can_supply_en}, 2'h0);
		init_pulse;
		dbg_window_pin = 1'b0;
		cyc(4);
		chk({debug_active, wd_required}, 2'h1);
		init_pulse;
		chk(safe_mode, 2'h3);
		{safe_cfg_wr, safe_cfg_data} = 3'h5;
		cyc(1);
		safe_cfg_wr = 1'b0;
		init_pulse;
		chk(safe_mode, 2'h1);
		$display("test debug finished");
		fault_pin = 1'b1;
		cyc(4);
		fault_pin = 1'b0;
		cyc(4);
		chk({safe_pin_oe, safe_pin_o}, 2'h2);
		// mid-run reset releases the sticky safe output and the spi settings
		rst_n = 1'b0;
		cyc(1);
		rst_n = 1'b1;
		cyc(1);
		chk({safe_pin_oe, safe_mode, int_n, can_supply_en}, 5'h02);
		$display("test safe finished");
		print_verdict;
	end
endmodule : tb
